// >>> src/chg_status_pkg.sv
// Behaviour
// - Charge-state pin driven low while a charge or recharge cycle is active.
// - Charge-state pin released high when done, asleep or charging disabled.
// - Charge-state pin blinks at 1 Hz during any charge or boost suspend.
// - Qualifying events give an active-low host alert pulse of 256 us; events during a pulse merge into it.
// - Alert pulse when input source type is identified as USB or adapter.
// - Alert pulse when the input becomes good.
// - Alert pulse on input removal, charge completion and any fault outside the thermistor field.
// - Alert pulse on regulation loop activity, maskable unlike other events.
// - Faults outside the thermistor field raise an alert and stay latched until the fault register is read.
// - No alert for new faults until the register is read and faults cleared.
// - First read returns latched status, the second returns the live status.
// - Function select value binary 11 disables the pin and leaves it floating.
// - Thermistor fault field always shows the present condition, never latched.
package chg_status_pkg;

  // Timing
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned ALERT_US        = 256;
  localparam int unsigned ALERT_CYC       = ALERT_US * CLK_MHZ;
  localparam int unsigned BLINK_HALF_MS   = 500;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // Fault register layout
  localparam int unsigned FAULT_W         = 8;
  localparam int unsigned THERM_LSB       = 0;
  localparam int unsigned THERM_W         = 3;
  localparam logic [7:0]  FAULT_RST       = 8'h00;

  // Pin function select
  localparam logic [1:0]  PIN_FUNC_OFF    = 2'b11;

  // Charger state as seen by the indicator
  typedef struct packed {
    logic charging;
    logic done;
    logic sleep;
    logic disabled;
    logic suspended;
  } chg_state_s;

  // Events toward the alert logic
  typedef struct packed {
    logic src_identified;
    logic input_good;
    logic input_removed;
    logic charge_done;
    logic regulation;
  } chg_event_s;

endpackage

// >>> src/alert_pulse.sv
`timescale 1ns/10ps
`default_nettype none
module alert_pulse
  import chg_status_pkg::*;
#(
  parameter int unsigned LEN = ALERT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Trigger and output
  input  wire logic fire,
  output var  logic alert_n
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        alert_n;
  } st_s;

  st_s st_q;
  st_s st_d;

  // A trigger during a running pulse merges into it rather than stretching it
  always_comb begin
    st_d = st_q;
    if (!st_q.alert_n) begin
      if (st_q.cnt == LEN - 1) begin
        st_d.alert_n = 1'b1;
        st_d.cnt     = '0;
      end else begin
        st_d.cnt = st_q.cnt + 32'h0000_0001;
      end
    end else if (fire) begin
      st_d.alert_n = 1'b0;
      st_d.cnt     = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{cnt: '0, alert_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign alert_n = st_q.alert_n;

endmodule
`default_nettype wire

// >>> src/charger_status_and_alert.sv
`timescale 1ns/10ps
`default_nettype none
module charger_status_and_alert
  import chg_status_pkg::*;
#(
  parameter int unsigned ALERT_LEN  = ALERT_CYC,
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // Charger state and events
  input  wire chg_state_s         CHG_STATE,
  input  wire chg_event_s         CHG_EVENT,
  input  wire logic               REG_MASK,
  input  wire logic [1:0]         PIN_FUNC_SEL,
  // Live fault conditions
  input  wire logic [FAULT_W-1:0] FAULT_LIVE,
  // Fault register read port
  input  wire logic               FAULT_RD,
  output logic [FAULT_W-1:0]      FAULT_RDATA,
  // Charge-state pin, open drain
  output logic                    STAT_O,
  output logic                    STAT_OE,
  // Host alert, active low
  output logic                    ALERT_N
);

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    PIN_LOW   = 3'b001,
    PIN_HIGH  = 3'b010,
    PIN_BLINK = 3'b100
  } pin_e;

  typedef struct packed {
    chg_state_s         prev_state;
    chg_event_s         prev_event;
    logic [FAULT_W-1:0] latch;
    logic [31:0]        blink_cnt;
    logic               blink_low;
    pin_e               pin;
    logic               stat_oe;
    logic [FAULT_W-1:0] rdata;
    logic               fire;
  } st_s;

  st_s  st_q;
  st_s  st_d;
  logic alert_n;

  localparam logic [FAULT_W-1:0] THERM_MASK =
    FAULT_W'(((1 << THERM_W) - 1) << THERM_LSB);

  //////////////////////////////////////////////////////////////////////////////
  // Next state: indicator, fault latch and event edges
  always_comb begin
    logic [FAULT_W-1:0] merged;
    logic               new_fault;
    logic               ev;
    merged    = '0;
    new_fault = 1'b0;
    ev        = 1'b0;
    st_d      = st_q;
    st_d.prev_state = CHG_STATE;
    st_d.prev_event = CHG_EVENT;

    // Pick the pin mode; suspend outranks charging
    if (CHG_STATE.suspended) begin
      st_d.pin = PIN_BLINK;
    end else if (CHG_STATE.charging) begin
      st_d.pin = PIN_LOW;
    end else begin
      st_d.pin = PIN_HIGH;
    end

    // Half-period counter, free running so phases stay even
    if (st_q.blink_cnt == BLINK_HALF - 1) begin
      st_d.blink_cnt = '0;
      st_d.blink_low = ~st_q.blink_low;
    end else begin
      st_d.blink_cnt = st_q.blink_cnt + 32'h0000_0001;
    end

    // Drive enable from the selected mode; high means pin pulled down
    if (PIN_FUNC_SEL == PIN_FUNC_OFF) begin
      st_d.stat_oe = 1'b0;
    end else begin
      case (st_d.pin)
        PIN_LOW:   st_d.stat_oe = 1'b1;
        PIN_BLINK: st_d.stat_oe = st_d.blink_low;
        default:   st_d.stat_oe = 1'b0;
      endcase
    end

    // Live faults join the latch; a read hands over and reloads from live
    new_fault = |(FAULT_LIVE & ~THERM_MASK & ~st_q.latch);
    merged    = st_q.latch | (FAULT_LIVE & ~THERM_MASK);
    if (FAULT_RD) begin
      st_d.rdata = (merged & ~THERM_MASK) | (FAULT_LIVE & THERM_MASK);
      st_d.latch = FAULT_LIVE & ~THERM_MASK;
    end else begin
      st_d.latch = merged;
    end

    // Edge-detected events; faults only alert while nothing is latched
    ev = (CHG_EVENT.src_identified & ~st_q.prev_event.src_identified)
       | (CHG_EVENT.input_good     & ~st_q.prev_event.input_good)
       | (CHG_EVENT.input_removed  & ~st_q.prev_event.input_removed)
       | (CHG_EVENT.charge_done    & ~st_q.prev_event.charge_done)
       | (CHG_EVENT.regulation & ~st_q.prev_event.regulation & ~REG_MASK)
       | (new_fault & (st_q.latch == '0));
    st_d.fire = ev;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '{prev_state: '0, prev_event: '0, latch: FAULT_RST, blink_cnt: '0,
                blink_low: 1'b0, pin: PIN_HIGH, stat_oe: 1'b0, rdata: FAULT_RST,
                fire: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fixed-length pulse generator
  alert_pulse #(
    .LEN     (ALERT_LEN)
  ) u_alert (
    .clk     (CLK),
    .rst_n   (RST_N),
    .fire    (st_q.fire),
    .alert_n (alert_n)
  );

  assign FAULT_RDATA = st_q.rdata;
  assign STAT_O      = 1'b0;      // Open drain only ever pulls low
  assign STAT_OE     = st_q.stat_oe;
  assign ALERT_N     = alert_n;

endmodule
`default_nettype wire

// >>> tb/chg_status_props.sv
`timescale 1ns/10ps
`default_nettype none
module chg_status_props
  import chg_status_pkg::*;
#(
  parameter int unsigned ALERT_LEN  = 8,
  parameter int unsigned BLINK_HALF = 16
) (
  // Watched ports
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire chg_state_s CHG_STATE,
  input wire chg_event_s CHG_EVENT,
  input wire logic       REG_MASK,
  input wire logic [1:0] PIN_FUNC_SEL,
  input wire logic [7:0] FAULT_LIVE,
  input wire logic       FAULT_RD,
  input wire logic [7:0] FAULT_RDATA,
  input wire logic       STAT_OE,
  input wire logic       ALERT_N
);
  int unsigned lo_q;
  int unsigned run_q;
  logic        act;
  // Blink is owed only while suspended with the pin enabled
  assign act = CHG_STATE.suspended && PIN_FUNC_SEL != PIN_FUNC_OFF;
  // Low-time of the alert and length of the current blink phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_q  <= 0;
      run_q <= 0;
    end else begin
      lo_q  <= ALERT_N ? 0 : lo_q + 1;
      run_q <= (!act || $changed(STAT_OE)) ? 0 : run_q + 1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////
  a_pulse_len: assert property ($rose(ALERT_N) |-> lo_q == ALERT_LEN)
    else $error("pulse length");
  a_pulse_max: assert property (!ALERT_N |-> lo_q < ALERT_LEN)
    else $error("pulse too long");
  a_event_alert: assert property (ALERT_N &&
    |(CHG_EVENT & ~$past(CHG_EVENT) & {4'hf, !REG_MASK}) |-> ##[1:2] !ALERT_N)
    else $error("event without alert");
  a_stat_low: assert property (CHG_STATE.charging && PIN_FUNC_SEL != PIN_FUNC_OFF &&
    !CHG_STATE.suspended |=> STAT_OE)
    else $error("pin not low");
  a_stat_free: assert property (!CHG_STATE.charging && !CHG_STATE.suspended |=> !STAT_OE)
    else $error("pin not released");
  a_pin_float: assert property (PIN_FUNC_SEL == PIN_FUNC_OFF |=> !STAT_OE)
    else $error("pin not floating");
  a_blink_phase: assert property (act |-> run_q < BLINK_HALF)
    else $error("blink phase too long");
  a_therm_live: assert property (FAULT_RD |=> FAULT_RDATA[2:0] == $past(FAULT_LIVE[2:0]))
    else $error("thermistor field latched");
endmodule
`default_nettype wire

// >>> tb/fault_host.sv
`timescale 1ns/10ps
`default_nettype none
module fault_host
  import chg_status_pkg::*;
(
  // Read port
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output var  logic       rd
);
  initial rd = 1'b0;
  // Two reads in a row; gap plus one idle cycles sit between them like a slow host
  task automatic read2(input int gap, output logic [7:0] a, output logic [7:0] b);
    for (int i = 0; i < 2; i++) begin
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      a = b;
      b = rdata;
      repeat (gap + 1) @(posedge clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import chg_status_pkg::*;
;
  logic       clk, rst_n, mask, rd, oe, al_n;
  logic [1:0] func;
  logic [7:0] live, rdata, a, b;
  chg_state_s st;
  chg_event_s ev;
  int         n_fail, total_checks, n;
  charger_status_and_alert #(.ALERT_LEN(8), .BLINK_HALF(16)) u_charger_status_and_alert (
    .CLK(clk), .RST_N(rst_n), .CHG_STATE(st), .CHG_EVENT(ev), .REG_MASK(mask),
    .PIN_FUNC_SEL(func), .FAULT_LIVE(live), .FAULT_RD(rd), .FAULT_RDATA(rdata),
    .STAT_O(), .STAT_OE(oe), .ALERT_N(al_n));
  fault_host u_fault_host (.clk(clk), .rdata(rdata), .rd(rd));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Expect or refuse an alert; a hung pulse ends the run
  task automatic pulse(input logic x);
    for (n = 0; al_n && n < 6; n++) step(1);
    chk("alert", {7'h0, x}, {7'h0, !al_n});
    for (n = 0; !al_n && n < 20; n++) step(1);
    if (x) chk("alert len", 8'h08, 8'(n));
    if (n == 20 || x && n == 0) results();
    step(2);
  endtask
  // Waits for the pin to change, at most 40 cycles
  task automatic wchg();
    logic p;
    p = oe;
    for (n = 0; oe === p && n < 40; n++) step(1);
    if (n == 40) begin
      n_fail++;
      $display("Error stat change expected toggle within 40 seen none");
      results();
    end
  endtask
  task automatic stat_levels();
    for (int i = 0; i < 5; i++) begin
      st = chg_state_s'(5'h10 >> (i % 4));
      func = i == 4 ? PIN_FUNC_OFF : 2'h0;
      step(2);
      chk("stat", {7'h0, i == 0}, {7'h0, oe});
    end
    func = 2'h0;
  endtask
  // First two changes only align to the free-running phase
  task automatic blink();
    st = chg_state_s'(5'h01);
    for (int i = 0; i < 4; i++) begin
      wchg();
      if (i > 1) chk("blink", 8'h10, 8'(n));
    end
    st = chg_state_s'(5'h00);
  endtask
  task automatic events();
    for (int i = 0; i < 6; i++) begin
      mask = i == 5;
      ev = chg_event_s'(5'h01 << (i % 5));
      pulse(i < 5);
      ev = chg_event_s'(5'h00);
      step(1);
    end
  endtask
  task automatic faults();
    live = 8'h08;
    pulse(1'b1);
    live = 8'h15;
    pulse(1'b0);
    live = 8'h10;
    u_fault_host.read2(0, a, b);
    chk("read 1", 8'h18, a);
    chk("read 2", 8'h10, b);
    live = 8'h00;
    u_fault_host.read2(3, a, b);
    chk("read 3", 8'h10, a);
    chk("read 4", 8'h00, b);
    live = 8'h20;
    pulse(1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    mask = 1'b0;
    func = 2'h0;
    live = 8'h00;
    st = chg_state_s'(5'h00);
    ev = chg_event_s'(5'h00);
    n_fail = 0;
    total_checks = 0;
    step(4);
    rst_n = 1'b1;
    step(1);
    stat_levels();
    blink();
    events();
    faults();
    results();
  end
endmodule
bind charger_status_and_alert chg_status_props #(.ALERT_LEN(ALERT_LEN),
  .BLINK_HALF(BLINK_HALF)) u_chg_status_props (.CLK(CLK), .RST_N(RST_N),
  .CHG_STATE(CHG_STATE), .CHG_EVENT(CHG_EVENT), .REG_MASK(REG_MASK),
  .PIN_FUNC_SEL(PIN_FUNC_SEL), .FAULT_LIVE(FAULT_LIVE), .FAULT_RD(FAULT_RD),
  .FAULT_RDATA(FAULT_RDATA), .STAT_OE(STAT_OE), .ALERT_N(ALERT_N));
`default_nettype wire
